// >>> shared/supervisor_map.vh
// Purpose: Offsets, field positions, reset values and timing counts of the reset supervisor.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one aligned word per register.
// Notes: Definitions only.
`ifndef SUPERVISOR_MAP_VH
`define SUPERVISOR_MAP_VH

`define SUP_ADDR_W 5
`define SUP_OFS_SUPPLY_CTRL 5'h00
`define SUP_OFS_WATCHDOG_CONTROL 5'h04
`define SUP_OFS_WATCHDOG_RESTART 5'h08
`define SUP_OFS_STATUS 5'h0C
`define SUP_OFS_IRQ_ENABLE 5'h10

// Supply control fields.
`define SUP_BOR_THR_LSB 0
`define SUP_CORE_BOI_THR_LSB 2
`define SUP_IO_BOI_THR_LSB 4
`define SUP_BOR_THR_RST 2'h0
`define SUP_BOI_THR_RST 2'h0

// Watchdog control fields.
`define WDC_EN_BIT 0
`define WDC_RST_EN_BIT 1
`define WDC_RATIO_LSB 2
`define WDC_LATE_BIT 4
`define WDC_RATIO_RST 2'h0

// Status fields; flags are write-one-to-clear.
`define ST_CORE_BOI_BIT 0
`define ST_IO_BOI_BIT 1
`define ST_WATCHDOG_IRQ_FLAG_BIT 2
`define ST_CORE_LOW_BIT 3
`define ST_IO_LOW_BIT 4
`define ST_CAUSE_POR_BIT 8
`define ST_CAUSE_BOR_BIT 9
`define ST_CAUSE_WD_BIT 10

// Timing.
`define RC_FREQ_KHZ 7600
`define PWRUP_TIME_US 8600
`define WD_IRQ_LOG2_BASE 12
`define WD_IRQ_LOG2_STEP 3
`define WD_RST_DELAY 512
`define WD_RST_HOLD_CYCLES 16
`define RESET_VECTOR 16'h8000

`endif

// >>> rtl/reset_brownout_watchdog_supervisor.v
// Purpose: Power-on, brownout and watchdog reset supervisor with brownout and watchdog interrupts.
// Assumes: RESET_N is low while the core supply is under the power-on threshold; comparator
// Assumes: inputs, the reset pin and the RC oscillator are asynchronous to CLK (250 MHz).
// Notes: The RC oscillator is sampled as a level and counted by its rising edges.
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_map.vh"

module reset_brownout_watchdog_supervisor #(
  parameter PWRUP_RC_CYCLES = `PWRUP_TIME_US * `RC_FREQ_KHZ / 1000
) (
  input wire CLK,
  input wire RESET_N,
  input wire RC_CLK,
  input wire CORE_BELOW_BOR,
  input wire CORE_BELOW_BOI,
  input wire IO_BELOW_BOI,
  input wire RST_PIN_IN,
  output reg RST_PIN_OUT,
  output reg RST_PIN_OE,
  output reg [1:0] CORE_BOR_THR,
  output reg [1:0] CORE_BOI_THR,
  output reg [1:0] IO_BOI_THR,
  output reg CPU_RESET_N,
  output reg CPU_START,
  output reg [15:0] FETCH_ADDR,
  output reg IRQ_REQ,
  input wire [`SUP_ADDR_W-1:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output reg AVS_WAITREQUEST
);

  localparam [2:0] S_POR_WAIT = 3'd0;
  localparam [2:0] S_PWRUP = 3'd1;
  localparam [2:0] S_RUN = 3'd2;
  localparam [2:0] S_BOR = 3'd3;
  localparam [2:0] S_WD_RST = 3'd4;
  // End counts are worked out at full integer width and then cut to the counter widths.
  localparam integer PWRUP_LAST_I = PWRUP_RC_CYCLES - 1;
  localparam integer WD_RST_LAST_I = `WD_RST_DELAY - 1;
  localparam integer WD_HOLD_LAST_I = `WD_RST_HOLD_CYCLES - 1;
  localparam [16:0] PWRUP_LAST = PWRUP_LAST_I[16:0];
  localparam [9:0] WD_RST_LAST = WD_RST_LAST_I[9:0];
  localparam [4:0] WD_HOLD_LAST = WD_HOLD_LAST_I[4:0];

  // Last count of the interrupt timeout for a ratio code: 2^(12+3*code) RC cycles.
  function [21:0] wd_limit;
    input [1:0] ratio;
    integer sh;
    begin
      sh = `WD_IRQ_LOG2_BASE + ratio * `WD_IRQ_LOG2_STEP;
      wd_limit = (22'h00_0001 << sh) - 22'h00_0001;
    end
  endfunction

  // Two-stage synchronisers; only the second stage is used by logic.
  reg [4:0] sync1_r;
  reg [4:0] sync2_r;
  reg rc_prev_r;
  wire rc_s = sync2_r[0];
  wire bor_low_s = sync2_r[1];
  wire core_low_s = sync2_r[2];
  wire io_low_s = sync2_r[3];
  wire pin_high_s = sync2_r[4];
  wire rc_tick = rc_s & ~rc_prev_r;

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync1_r <= 5'h10;
      sync2_r <= 5'h10;
      rc_prev_r <= 1'b0;
    end else begin
      sync1_r <= {RST_PIN_IN, IO_BELOW_BOI, CORE_BELOW_BOI, CORE_BELOW_BOR, RC_CLK};
      sync2_r <= sync1_r;
      rc_prev_r <= rc_s;
    end
  end

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [16:0] pwr_cnt_r;
  reg [4:0] hold_cnt_r;
  reg wd_fire;
  wire sys_rst = ~CPU_RESET_N;

  // Avalon-MM decode; a write lands on the edge where waitrequest is sampled low.
  wire req = AVS_READ | AVS_WRITE;
  wire wr_go = AVS_WRITE & ~AVS_WAITREQUEST & AVS_BYTEENABLE[0] & ~sys_rst;
  wire wr_go1 = AVS_WRITE & ~AVS_WAITREQUEST & AVS_BYTEENABLE[1] & ~sys_rst;
  wire wr_supply = wr_go & (AVS_ADDRESS == `SUP_OFS_SUPPLY_CTRL);
  wire wr_wdc = wr_go & (AVS_ADDRESS == `SUP_OFS_WATCHDOG_CONTROL);
  wire wr_kick = AVS_WRITE & ~AVS_WAITREQUEST & ~sys_rst & (AVS_ADDRESS == `SUP_OFS_WATCHDOG_RESTART);
  wire wr_stat = wr_go & (AVS_ADDRESS == `SUP_OFS_STATUS);
  wire wr_stat1 = wr_go1 & (AVS_ADDRESS == `SUP_OFS_STATUS);
  wire wr_irqen = wr_go & (AVS_ADDRESS == `SUP_OFS_IRQ_ENABLE);

  // Supervisor sequence.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_POR_WAIT: begin
        if (!bor_low_s) begin
          state_nxt = S_PWRUP;
        end
      end
      S_PWRUP: begin
        if (bor_low_s) begin
          state_nxt = S_POR_WAIT;
        end else if (rc_tick && pwr_cnt_r == PWRUP_LAST) begin
          state_nxt = S_RUN;
        end
      end
      S_RUN: begin
        if (bor_low_s) begin
          state_nxt = S_BOR;
        end else if (wd_fire) begin
          state_nxt = S_WD_RST;
        end
      end
      S_BOR: begin
        if (!bor_low_s) begin
          state_nxt = S_RUN;
        end
      end
      S_WD_RST: begin
        if (bor_low_s) begin
          state_nxt = S_BOR;
        end else if (hold_cnt_r == WD_HOLD_LAST) begin
          state_nxt = S_RUN;
        end
      end
      default: state_nxt = S_POR_WAIT;
    endcase
  end

  // A drop under the power-on threshold lands here through RESET_N, so recovery restarts
  // from S_POR_WAIT with the full power-up delay.
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= S_POR_WAIT;
      pwr_cnt_r <= 17'h0_0000;
      hold_cnt_r <= 5'h00;
    end else begin
      state_r <= state_nxt;
      if (state_r != S_PWRUP) begin
        pwr_cnt_r <= 17'h0_0000;
      end else if (rc_tick) begin
        pwr_cnt_r <= pwr_cnt_r + 17'h0_0001;
      end
      if (state_r != S_WD_RST) begin
        hold_cnt_r <= 5'h00;
      end else begin
        hold_cnt_r <= hold_cnt_r + 5'h01;
      end
    end
  end

  // Pin and core reset. The core also stays in reset while anyone holds the pin low, and the
  // release waits for the pull-up to be seen high through the synchroniser.
  wire drive_low = (state_nxt != S_RUN);
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RST_PIN_OUT <= 1'b0;
      RST_PIN_OE <= 1'b1;
      CPU_RESET_N <= 1'b0;
      CPU_START <= 1'b0;
      FETCH_ADDR <= `RESET_VECTOR;
    end else begin
      RST_PIN_OUT <= 1'b0;
      RST_PIN_OE <= drive_low;
      CPU_RESET_N <= (state_r == S_RUN) & ~drive_low & ~RST_PIN_OE & pin_high_s;
      CPU_START <= ~CPU_RESET_N & (state_r == S_RUN) & ~drive_low & ~RST_PIN_OE & pin_high_s;
      FETCH_ADDR <= `RESET_VECTOR;
    end
  end

  // Registers. The brownout-reset threshold only returns to default at power-on.
  reg [1:0] wd_ratio_r;
  reg wd_en_r;
  reg wd_rst_en_r;
  reg wd_late_r;
  reg [21:0] wd_cnt_r;
  reg [2:0] irq_en_r;
  reg core_boi_r;
  reg io_boi_r;
  reg watchdog_irq_flag_r;
  reg cause_por_r;
  reg cause_bor_r;
  reg cause_wd_r;

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CORE_BOR_THR <= `SUP_BOR_THR_RST;
    end else if (wr_supply) begin
      CORE_BOR_THR <= AVS_WRITEDATA[`SUP_BOR_THR_LSB +: 2];
    end
  end

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CORE_BOI_THR <= `SUP_BOI_THR_RST;
      IO_BOI_THR <= `SUP_BOI_THR_RST;
      wd_ratio_r <= `WDC_RATIO_RST;
      wd_en_r <= 1'b0;
      wd_rst_en_r <= 1'b0;
      irq_en_r <= 3'h0;
    end else if (sys_rst) begin
      CORE_BOI_THR <= `SUP_BOI_THR_RST;
      IO_BOI_THR <= `SUP_BOI_THR_RST;
      wd_ratio_r <= `WDC_RATIO_RST;
      wd_en_r <= 1'b0;
      wd_rst_en_r <= 1'b0;
      irq_en_r <= 3'h0;
    end else begin
      if (wr_supply) begin
        CORE_BOI_THR <= AVS_WRITEDATA[`SUP_CORE_BOI_THR_LSB +: 2];
        IO_BOI_THR <= AVS_WRITEDATA[`SUP_IO_BOI_THR_LSB +: 2];
      end
      if (wr_wdc) begin
        wd_en_r <= AVS_WRITEDATA[`WDC_EN_BIT];
        wd_rst_en_r <= AVS_WRITEDATA[`WDC_RST_EN_BIT];
        wd_ratio_r <= AVS_WRITEDATA[`WDC_RATIO_LSB +: 2];
      end
      if (wr_irqen) begin
        irq_en_r <= AVS_WRITEDATA[2:0];
      end
    end
  end

  // Watchdog, counted on RC edges only. Early phase runs to the interrupt timeout, late
  // phase counts the fixed reset delay.
  wire ratio_change = wr_wdc & (AVS_WRITEDATA[`WDC_RATIO_LSB +: 2] != wd_ratio_r);
  wire wd_run = wd_en_r & ~sys_rst;
  wire wd_irq_hit = wd_run & rc_tick & ~wd_late_r & (wd_cnt_r == wd_limit(wd_ratio_r));
  wire wd_rst_hit = wd_run & rc_tick & wd_late_r & (wd_cnt_r[9:0] == WD_RST_LAST);

  always @* begin
    wd_fire = wd_rst_hit & wd_rst_en_r;
  end

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wd_cnt_r <= 22'h00_0000;
      wd_late_r <= 1'b0;
    end else if (!wd_run || wr_kick) begin
      wd_cnt_r <= 22'h00_0000;
      wd_late_r <= 1'b0;
    end else if (ratio_change && !wd_late_r) begin
      wd_cnt_r <= 22'h00_0000;
    end else if (wd_irq_hit) begin
      wd_cnt_r <= 22'h00_0000;
      wd_late_r <= 1'b1;
    end else if (wd_rst_hit) begin
      wd_cnt_r <= 22'h00_0000;
      wd_late_r <= 1'b0;
    end else if (rc_tick) begin
      wd_cnt_r <= wd_cnt_r + 22'h00_0001;
    end
  end

  // Sticky flags: a new event in the clearing cycle wins over the clear. Cause bits take
  // their brownout values on a brownout out of S_RUN rather than the power-on ones.
  wire boi_clr_core = wr_stat & AVS_WRITEDATA[`ST_CORE_BOI_BIT];
  wire boi_clr_io = wr_stat & AVS_WRITEDATA[`ST_IO_BOI_BIT];
  wire watchdog_irq_flag_clr = wr_stat & AVS_WRITEDATA[`ST_WATCHDOG_IRQ_FLAG_BIT];
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      core_boi_r <= 1'b0;
      io_boi_r <= 1'b0;
      watchdog_irq_flag_r <= 1'b0;
      cause_por_r <= 1'b1;
      cause_bor_r <= 1'b0;
      cause_wd_r <= 1'b0;
    end else begin
      core_boi_r <= core_low_s | (core_boi_r & ~boi_clr_core);
      io_boi_r <= io_low_s | (io_boi_r & ~boi_clr_io);
      watchdog_irq_flag_r <= wd_irq_hit | (watchdog_irq_flag_r & ~watchdog_irq_flag_clr);
      if (state_r == S_RUN && state_nxt == S_BOR) begin
        cause_por_r <= 1'b0;
        cause_bor_r <= 1'b1;
        cause_wd_r <= 1'b0;
      end else if (wd_fire && state_r == S_RUN) begin
        cause_por_r <= 1'b0;
        cause_bor_r <= 1'b0;
        cause_wd_r <= 1'b1;
      end else if (wr_stat1) begin
        cause_por_r <= cause_por_r & ~AVS_WRITEDATA[`ST_CAUSE_POR_BIT];
        cause_bor_r <= cause_bor_r & ~AVS_WRITEDATA[`ST_CAUSE_BOR_BIT];
        cause_wd_r <= cause_wd_r & ~AVS_WRITEDATA[`ST_CAUSE_WD_BIT];
      end
    end
  end

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IRQ_REQ <= 1'b0;
    end else begin
      IRQ_REQ <= |({watchdog_irq_flag_r, io_boi_r, core_boi_r} & irq_en_r);
    end
  end

  // Bus answer: one wait cycle, then waitrequest low for one cycle with the read data.
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (AVS_ADDRESS)
      `SUP_OFS_SUPPLY_CTRL: begin
        rd_mux[`SUP_BOR_THR_LSB +: 2] = CORE_BOR_THR;
        rd_mux[`SUP_CORE_BOI_THR_LSB +: 2] = CORE_BOI_THR;
        rd_mux[`SUP_IO_BOI_THR_LSB +: 2] = IO_BOI_THR;
      end
      `SUP_OFS_WATCHDOG_CONTROL: begin
        rd_mux[`WDC_EN_BIT] = wd_en_r;
        rd_mux[`WDC_RST_EN_BIT] = wd_rst_en_r;
        rd_mux[`WDC_RATIO_LSB +: 2] = wd_ratio_r;
        rd_mux[`WDC_LATE_BIT] = wd_late_r;
      end
      `SUP_OFS_STATUS: begin
        rd_mux[`ST_CORE_BOI_BIT] = core_boi_r;
        rd_mux[`ST_IO_BOI_BIT] = io_boi_r;
        rd_mux[`ST_WATCHDOG_IRQ_FLAG_BIT] = watchdog_irq_flag_r;
        rd_mux[`ST_CORE_LOW_BIT] = core_low_s;
        rd_mux[`ST_IO_LOW_BIT] = io_low_s;
        rd_mux[`ST_CAUSE_POR_BIT] = cause_por_r;
        rd_mux[`ST_CAUSE_BOR_BIT] = cause_bor_r;
        rd_mux[`ST_CAUSE_WD_BIT] = cause_wd_r;
      end
      `SUP_OFS_IRQ_ENABLE: begin
        rd_mux[2:0] = irq_en_r;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0000_0000;
    end else begin
      AVS_WAITREQUEST <= ~(req & AVS_WAITREQUEST);
      if (AVS_READ && AVS_WAITREQUEST) begin
        AVS_READDATA <= rd_mux;
      end
    end
  end

endmodule
`default_nettype wire

// >>> verification/supervisor_chk.sv
// Purpose: Concurrent checks on the pins of the reset, brownout and watchdog supervisor.
// Assumes: One clock domain; RESET_N stands for loss of the core supply below power-on level.
// Notes: Supply and pin inputs pass two synchroniser flops, so relations allow that lag.
`timescale 1ns/1ps
`default_nettype none
module supervisor_chk #(
  parameter PWRUP_RC_CYCLES = 8
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CORE_BELOW_BOR,
  input wire logic RST_PIN_IN,
  input wire logic RST_PIN_OUT,
  input wire logic RST_PIN_OE,
  input wire logic [1:0] CORE_BOR_THR,
  input wire logic [1:0] CORE_BOI_THR,
  input wire logic CPU_RESET_N,
  input wire logic CPU_START,
  input wire logic [15:0] FETCH_ADDR,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  sequence s_cpu_up;
    !CPU_RESET_N ##1 CPU_RESET_N;
  endsequence
  sequence s_start_pulse;
    CPU_START ##1 !CPU_START;
  endsequence
  AST_START_PULSE: assert property (s_cpu_up |-> s_start_pulse)
    else $error("start pulse missing at core release");
  AST_START_ONLY: assert property (CPU_START |-> CPU_RESET_N && !$past(CPU_RESET_N))
    else $error("start pulse without core release");
  AST_FETCH_VEC: assert property (FETCH_ADDR == 16'h8000)
    else $error("fetch address is not the reset vector");
  AST_OPEN_DRAIN: assert property (RST_PIN_OUT == 1'b0)
    else $error("reset pin driven high");
  // The power-on state is judged on the second edge in reset, once the asynchronous clear has landed.
  AST_POR_STATE: assert property (disable iff (1'b0) !RESET_N [*2] |->
    RST_PIN_OE && !CPU_RESET_N && CORE_BOR_THR == 2'h0 && CORE_BOI_THR == 2'h0)
    else $error("power-on state not applied");
  AST_BOR_HOLDS: assert property (CORE_BELOW_BOR [*6] |-> RST_PIN_OE && !CPU_RESET_N)
    else $error("low core supply does not hold reset");
  AST_OE_HOLDS_CPU: assert property (RST_PIN_OE |=> !CPU_RESET_N)
    else $error("core running while pin driven");
  AST_PIN_HOLDS_CPU: assert property (!RST_PIN_IN [*4] |-> !CPU_RESET_N)
    else $error("core running while pin held low");
  AST_THR_BY_BUS: assert property ($changed(CORE_BOR_THR) |-> $past(AVS_WRITE && !AVS_WAITREQUEST))
    else $error("reset threshold changed without a write");
  AST_RELEASE_OK: assert property ($fell(RST_PIN_OE) |-> !$past(CORE_BELOW_BOR, 2))
    else $error("pin released while core supply low");
endmodule
bind reset_brownout_watchdog_supervisor supervisor_chk #(
  .PWRUP_RC_CYCLES(PWRUP_RC_CYCLES)
) u_chk (
  .CLK(CLK), .RESET_N(RESET_N), .CORE_BELOW_BOR(CORE_BELOW_BOR), .RST_PIN_IN(RST_PIN_IN),
  .RST_PIN_OUT(RST_PIN_OUT), .RST_PIN_OE(RST_PIN_OE), .CORE_BOR_THR(CORE_BOR_THR),
  .CORE_BOI_THR(CORE_BOI_THR), .CPU_RESET_N(CPU_RESET_N), .CPU_START(CPU_START),
  .FETCH_ADDR(FETCH_ADDR), .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST)
);
`default_nettype wire

// >>> verification/supply_pin_model.sv
// Purpose: Supply comparators, RC oscillator and open-drain reset pin around the supervisor.
// Assumes: Comparator levels come from the bench; the pin has a weak pull-up.
// Notes: The oscillator runs free, unrelated in phase to CLK.
`timescale 1ns/1ps
`default_nettype none
module supply_pin_model (
  input wire logic core_low,
  input wire logic core_warn,
  input wire logic io_warn,
  input wire logic ext_low,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic rc_clk,
  output logic core_below_bor,
  output logic core_below_boi,
  output logic io_below_boi,
  output logic pin_level
);
  // A fast stand-in for the oscillator keeps watchdog runs short; ten CLK cycles a period.
  initial begin
    rc_clk = 1'b0;
    #7;
    forever #20 rc_clk = ~rc_clk;
  end
  assign core_below_bor = core_low;
  assign core_below_boi = core_warn;
  assign io_below_boi = io_warn;
  // Either party may pull low; the pull-up wins only when both let go.
  assign pin_level = !(pin_oe && !pin_out) && !ext_low;
endmodule
`default_nettype wire

// >>> verification/reset_brownout_watchdog_supervisor_tb.sv
// Purpose: Self-checking bench for the reset, brownout and watchdog supervisor.
// Assumes: Power-up count shortened to PU RC cycles; RC edges are counted by the bench.
// Notes: RC timings allow two RC edges of slack for the synchronisers.
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_map.vh"
module reset_brownout_watchdog_supervisor_tb;
  localparam int PU = 8;
  logic CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic core_low = 1'b1;
  logic core_warn = 1'b0;
  logic io_warn = 1'b0;
  logic ext_low = 1'b1;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [4:0] AVS_ADDRESS = 5'h00;
  logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
  logic [31:0] AVS_READDATA, q;
  logic AVS_WAITREQUEST, RC_CLK, CORE_BELOW_BOR, CORE_BELOW_BOI, IO_BELOW_BOI, RST_PIN_IN;
  logic RST_PIN_OUT, RST_PIN_OE, CPU_RESET_N, CPU_START, IRQ_REQ;
  logic [1:0] CORE_BOR_THR, CORE_BOI_THR, IO_BOI_THR;
  logic [15:0] FETCH_ADDR;
  int err_total = 0;
  int num_checks = 0;
  int rc_n = 0;
  int t0, cyc;
  reset_brownout_watchdog_supervisor #(.PWRUP_RC_CYCLES(PU)) dut (
    .CLK(CLK), .RESET_N(RESET_N), .RC_CLK(RC_CLK), .CORE_BELOW_BOR(CORE_BELOW_BOR),
    .CORE_BELOW_BOI(CORE_BELOW_BOI), .IO_BELOW_BOI(IO_BELOW_BOI), .RST_PIN_IN(RST_PIN_IN),
    .RST_PIN_OUT(RST_PIN_OUT), .RST_PIN_OE(RST_PIN_OE), .CORE_BOR_THR(CORE_BOR_THR),
    .CORE_BOI_THR(CORE_BOI_THR), .IO_BOI_THR(IO_BOI_THR), .CPU_RESET_N(CPU_RESET_N),
    .CPU_START(CPU_START), .FETCH_ADDR(FETCH_ADDR), .IRQ_REQ(IRQ_REQ), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST)
  );
  supply_pin_model u_supply (
    .core_low(core_low), .core_warn(core_warn), .io_warn(io_warn), .ext_low(ext_low),
    .pin_out(RST_PIN_OUT), .pin_oe(RST_PIN_OE), .rc_clk(RC_CLK), .core_below_bor(CORE_BELOW_BOR),
    .core_below_boi(CORE_BELOW_BOI), .io_below_boi(IO_BELOW_BOI), .pin_level(RST_PIN_IN)
  );
  always #2 CLK = ~CLK;
  always @(posedge RC_CLK) rc_n <= rc_n + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk(32'(got), 32'(exp));
  endtask
  task automatic chk_range(input int v, input int lo, input int hi);
    num_checks++;
    if (v < lo || v > hi) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
    end
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return CPU_RESET_N;
      1: return RST_PIN_OE;
      default: return IRQ_REQ;
    endcase
  endfunction
  task automatic wait_sig(input int s, input logic v, input int lim);
    cyc = 0;
    while (sig(s) !== v && cyc < lim) begin
      @(posedge CLK);
      cyc++;
    end
    chkb(sig(s), v);
  endtask
  // Entered just after an edge; the request holds until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    do begin
      @(posedge CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
    r = AVS_READDATA;
    chkb(n < 50, 1'b1);
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q & m, e);
  endtask
  task automatic pwr_up;
    repeat (20) @(posedge CLK);
    chkb(RST_PIN_OE, 1'b1);
    core_low <= 1'b0;
    t0 = rc_n;
    wait_sig(1, 1'b0, 400);
    chk_range(rc_n - t0, PU, PU + 2);
  endtask
  task automatic t_power_up;
    rdc(`SUP_OFS_SUPPLY_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc(`SUP_OFS_WATCHDOG_CONTROL, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc(5'h14, 32'hFFFF_FFFF, 32'h0000_0000);
    pwr_up;
    repeat (20) @(posedge CLK);
    chkb(CPU_RESET_N, 1'b0);
    ext_low <= 1'b0;
    wait_sig(0, 1'b1, 10);
    chkb(CPU_START, 1'b1);
    chk(32'(FETCH_ADDR), 32'h0000_8000);
  endtask
  task automatic t_brownout;
    wr(`SUP_OFS_SUPPLY_CTRL, 32'h0000_0036);
    wr(`SUP_OFS_WATCHDOG_CONTROL, 32'h0000_000C);
    chk(32'({CORE_BOR_THR, CORE_BOI_THR, IO_BOI_THR}), 32'h0000_0027);
    core_low <= 1'b1;
    wait_sig(1, 1'b1, 10);
    repeat (100) @(posedge CLK);
    chkb(CPU_RESET_N, 1'b0);
    chkb(RST_PIN_OE, 1'b1);
    core_low <= 1'b0;
    wait_sig(0, 1'b1, 20);
    rdc(`SUP_OFS_SUPPLY_CTRL, 32'h0000_003F, 32'h0000_0002);
    rdc(`SUP_OFS_WATCHDOG_CONTROL, 32'h0000_001F, 32'h0000_0000);
    rdc(`SUP_OFS_STATUS, 32'h0000_0200, 32'h0000_0200);
  endtask
  task automatic t_por;
    core_low <= 1'b1;
    RESET_N <= 1'b0;
    repeat (3) @(posedge CLK);
    chk(32'(CORE_BOR_THR), 32'h0000_0000);
    RESET_N <= 1'b1;
    pwr_up;
    wait_sig(0, 1'b1, 10);
  endtask
  task automatic t_boi;
    wr(`SUP_OFS_IRQ_ENABLE, 32'h0000_0002);
    io_warn <= 1'b1;
    wait_sig(2, 1'b1, 20);
    io_warn <= 1'b0;
    repeat (10) @(posedge CLK);
    chkb(IRQ_REQ, 1'b1);
    wr(`SUP_OFS_STATUS, 32'h0000_0002);
    wait_sig(2, 1'b0, 10);
    wr(`SUP_OFS_IRQ_ENABLE, 32'h0000_0000);
    core_warn <= 1'b1;
    repeat (10) @(posedge CLK);
    chkb(IRQ_REQ, 1'b0);
    rdc(`SUP_OFS_STATUS, 32'h0000_0003, 32'h0000_0001);
    core_warn <= 1'b0;
    repeat (5) @(posedge CLK);
    wr(`SUP_OFS_STATUS, 32'h0000_0001);
    rdc(`SUP_OFS_STATUS, 32'h0000_0003, 32'h0000_0000);
  endtask
  task automatic t_watchdog;
    wr(`SUP_OFS_IRQ_ENABLE, 32'h0000_0004);
    wr(`SUP_OFS_WATCHDOG_CONTROL, 32'h0000_0003);
    wr(`SUP_OFS_WATCHDOG_RESTART, 32'h0000_0000);
    repeat (3000) @(posedge RC_CLK);
    @(posedge CLK);
    wr(`SUP_OFS_WATCHDOG_CONTROL, 32'h0000_0007);
    rdc(`SUP_OFS_WATCHDOG_CONTROL, 32'h0000_000C, 32'h0000_0004);
    wr(`SUP_OFS_WATCHDOG_CONTROL, 32'h0000_0003);
    t0 = rc_n;
    wait_sig(2, 1'b1, 41500);
    chk_range(rc_n - t0, 4094, 4098);
    t0 = rc_n;
    wait_sig(1, 1'b1, 5400);
    chk_range(rc_n - t0, 510, 514);
    wait_sig(0, 1'b1, 100);
    rdc(`SUP_OFS_WATCHDOG_CONTROL, 32'h0000_001F, 32'h0000_0000);
    rdc(`SUP_OFS_STATUS, 32'h0000_0404, 32'h0000_0404);
  endtask
  task automatic finish_test;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge CLK);
    err_total++;
    finish_test;
  end
  initial begin
    repeat (10) @(posedge CLK);
    RESET_N <= 1'b1;
    t_power_up;
    t_brownout;
    t_por;
    t_boi;
    t_watchdog;
    finish_test;
  end
endmodule
`default_nettype wire
